// file: inc/bcr_pkg.sv
// Purpose: Shared constants and types for the buck channel control registers.
// Assumes: 10-bit registers at 5-bit addresses, reached from the serial interface logic.
// Notes:   All reset values are zero.
package bcr_pkg;

  localparam int unsigned DATA_W = 10;
  localparam int unsigned ADDR_W = 5;

  localparam logic [ADDR_W-1:0] ADDR_CH2_PEAK_VALUE = 5'h02;
  localparam logic [ADDR_W-1:0] ADDR_PEAK_RANGE     = 5'h03;
  localparam logic [ADDR_W-1:0] ADDR_OFF_TIME       = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_GENERAL        = 5'h05;
  localparam logic [ADDR_W-1:0] ADDR_DRIVER         = 5'h06;
  localparam logic [ADDR_W-1:0] ADDR_TRIM_FIRST     = 5'h18;
  localparam logic [ADDR_W-1:0] ADDR_TRIM_LAST      = 5'h1a;

  localparam logic [DATA_W-1:0] RESET_VALUE = 10'h000;

  // Peak range register: channel two range code.
  localparam int unsigned RANGE_LSB = 0;
  localparam logic [2:0]  RANGE_MAX = 3'h4;

  // Off-time register fields.
  localparam int unsigned TOFF1_LSB = 5;
  localparam int unsigned TOFF2_LSB = 0;

  // General settings register fields.
  localparam int unsigned GEN_OCD1_BIT  = 9;
  localparam int unsigned GEN_OCD2_BIT  = 8;
  localparam int unsigned GEN_SLOW_BIT  = 7;
  localparam int unsigned GEN_OCF_LSB   = 5;
  localparam int unsigned GEN_FSM_LSB   = 2;
  localparam int unsigned GEN_EN1_BIT   = 1;
  localparam int unsigned GEN_EN2_BIT   = 0;

  // Driver settings register fields.
  localparam int unsigned DRV_SYNC_BIT  = 9;
  localparam int unsigned DRV_NO1_LSB   = 7;
  localparam int unsigned DRV_NO2_LSB   = 5;
  localparam int unsigned DRV_LS1_BIT   = 4;
  localparam int unsigned DRV_LS2_BIT   = 3;
  localparam int unsigned DRV_REV1_BIT  = 2;
  localparam int unsigned DRV_REV2_BIT  = 1;
  localparam int unsigned DRV_BANK_BIT  = 0;

  // Fail-safe mode codes.
  localparam logic [2:0] FSM_OFF_SAFE      = 3'h0;
  localparam logic [2:0] FSM_OFF_OTP       = 3'h1;
  localparam logic [2:0] FSM_ON_SAFE       = 3'h2;
  localparam logic [2:0] FSM_ON_SAFE_UPD   = 3'h3;
  localparam logic [2:0] FSM_ON_OTP        = 3'h4;
  localparam logic [2:0] FSM_ON_OTP_UPD    = 3'h5;
  localparam logic [2:0] FSM_ALONE_OTP     = 3'h6;
  localparam logic [2:0] FSM_ALONE_OTP_UPD = 3'h7;

  typedef struct packed {
    logic       regulator_enable;
    logic [4:0] off_time_constant;
    logic       offset_cancel_disable;
    logic [1:0] nonoverlap_select;
    logic       lowside_predriver_enable;
    logic       reverse_current_ignore;
  } bcr_chan_s;

  typedef struct packed {
    logic failsafe_operation;
    logic standalone;
    logic load_from_otp;
    logic spi_update_in_failsafe;
  } bcr_failsafe_s;

endpackage

// file: rtl/bcr_buck_regs.sv
// Purpose: Buck channel configuration registers with decoded controls for the analog channels.
// Assumes: Register port is driven by the serial interface logic on the same clock.
// Notes:   Read data is registered one cycle after the read strobe.
// Notes on behaviour
// - Channel two range code is three bits; 000..100 select ranges one to five.
// - New range takes effect only after channel two peak value is written.
// - Five-bit off-time codes, channel one upper, channel two lower bits.
// - Offset cancel bit: 0 keeps compensation, 1 turns it off per channel.
// - Slope bit: 0 normal, 1 slow high-side driver slopes.
// - Over-current filter codes 00..11 require more than one to four periods.
// - Fail-safe codes 000 and 001: fail-safe off, safe or OTP load.
// - Codes 010..101 enable fail-safe; 011 and 101 allow SPI updates.
// - Codes 110 and 111: stand-alone, OTP load; 111 allows SPI updates.
// - Channel enable bits 1 and 0; channel regulates only while set.
// - Sync bit: 0 independent channels, 1 master-slave synchronous operation.
// - Two-bit non-overlap select per channel: adaptive or fixed dead time.
// - Low-side pre-driver enable: 0 asynchronous, 1 synchronous with pre-driver.
// - Reverse-current bit: 0 stop on zero current, 1 hold till off-time end.
// - Bank bit picks channel one or two trimming constants at 0x18..0x1A.
module bcr_buck_regs (
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_nrst,
  input  wire logic                     i_wr_en,
  input  wire logic                     i_rd_en,
  input  wire logic [4:0]               i_addr,
  input  wire logic [9:0]               i_wdata,
  output logic      [9:0]               o_rdata,
  output logic                          o_trim_read_ch2,
  output logic      [2:0]               o_ch2_range_active,
  output bcr_pkg::bcr_chan_s            o_ch1,
  output bcr_pkg::bcr_chan_s            o_ch2,
  output logic                          o_driver_slope_slow,
  output logic      [1:0]               o_overcurrent_filter_periods,
  output logic      [2:0]               o_failsafe_mode_select,
  output bcr_pkg::bcr_failsafe_s        o_failsafe,
  output logic                          o_sync_enable
);

  logic [2:0]                 range_pend_q;
  logic [2:0]                 range_act_q;
  logic [bcr_pkg::DATA_W-1:0] off_time_q;
  logic [bcr_pkg::DATA_W-1:0] gen_q;
  logic [bcr_pkg::DATA_W-1:0] drv_q;
  logic [bcr_pkg::DATA_W-1:0] rdata_q;
  logic [bcr_pkg::DATA_W-1:0] rd_mux;
  logic                       trim_sel;
  logic                       range_wr;
  logic                       value_wr;
  logic                       range_legal;

  // The decode below assumes the port widths and field places that the package describes.
  if ($bits(i_wdata) != bcr_pkg::DATA_W) begin : g_bad_data_w
    $error("write data width does not match the register word");
  end
  if ($bits(i_addr) != bcr_pkg::ADDR_W) begin : g_bad_addr_w
    $error("address width does not match the register map");
  end
  if (bcr_pkg::ADDR_TRIM_FIRST > bcr_pkg::ADDR_TRIM_LAST) begin : g_bad_trim
    $error("trimming window bounds are reversed");
  end
  if (bcr_pkg::GEN_FSM_LSB + $bits(o_failsafe_mode_select) > bcr_pkg::DATA_W) begin : g_bad_fsm
    $error("fail-safe field runs past the register word");
  end
  if (bcr_pkg::GEN_OCF_LSB + $bits(o_overcurrent_filter_periods) > bcr_pkg::DATA_W) begin : g_bad_ocf
    $error("over-current filter field runs past the register word");
  end
  if (bcr_pkg::RANGE_LSB + $bits(range_pend_q) > bcr_pkg::DATA_W) begin : g_bad_range
    $error("range field runs past the register word");
  end

  assign range_wr = i_wr_en && (i_addr == bcr_pkg::ADDR_PEAK_RANGE);

  assign value_wr = i_wr_en && (i_addr == bcr_pkg::ADDR_CH2_PEAK_VALUE);

  // Codes above range five are never applied, so the previous range stays in force.
  assign range_legal = range_pend_q <= bcr_pkg::RANGE_MAX;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      range_pend_q <= bcr_pkg::RESET_VALUE[2:0];
    end else if (range_wr) begin
      range_pend_q <= i_wdata[bcr_pkg::RANGE_LSB +: 3];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      range_act_q <= bcr_pkg::RESET_VALUE[2:0];
    end else if (value_wr && range_legal) begin
      range_act_q <= range_pend_q;
    end
  end

  bcr_cfg_reg #(
    .WIDTH (bcr_pkg::DATA_W),
    .ADDR  (bcr_pkg::ADDR_OFF_TIME),
    .RST   (bcr_pkg::RESET_VALUE)
  ) u_off_time_reg (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_wr_en   (i_wr_en),
    .i_addr    (i_addr),
    .i_wdata   (i_wdata),
    .o_value   (off_time_q)
  );

  bcr_cfg_reg #(
    .WIDTH (bcr_pkg::DATA_W),
    .ADDR  (bcr_pkg::ADDR_GENERAL),
    .RST   (bcr_pkg::RESET_VALUE)
  ) u_gen_reg (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_wr_en   (i_wr_en),
    .i_addr    (i_addr),
    .i_wdata   (i_wdata),
    .o_value   (gen_q)
  );

  bcr_cfg_reg #(
    .WIDTH (bcr_pkg::DATA_W),
    .ADDR  (bcr_pkg::ADDR_DRIVER),
    .RST   (bcr_pkg::RESET_VALUE)
  ) u_drv_reg (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_wr_en   (i_wr_en),
    .i_addr    (i_addr),
    .i_wdata   (i_wdata),
    .o_value   (drv_q)
  );

  // Read mux; unmapped addresses and the trimming window read zero here.
  always_comb begin
    rd_mux = bcr_pkg::RESET_VALUE;
    case (i_addr)
      bcr_pkg::ADDR_PEAK_RANGE: rd_mux[bcr_pkg::RANGE_LSB +: 3] = range_pend_q;
      bcr_pkg::ADDR_OFF_TIME:   rd_mux = off_time_q;
      bcr_pkg::ADDR_GENERAL:    rd_mux = gen_q;
      bcr_pkg::ADDR_DRIVER:     rd_mux = drv_q;
      default:                  rd_mux = bcr_pkg::RESET_VALUE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= bcr_pkg::RESET_VALUE;
    end else if (i_rd_en) begin
      rdata_q <= rd_mux;
    end
  end

  assign o_rdata = rdata_q;

  assign trim_sel        = i_addr >= bcr_pkg::ADDR_TRIM_FIRST && i_addr <= bcr_pkg::ADDR_TRIM_LAST;
  assign o_trim_read_ch2 = trim_sel && drv_q[bcr_pkg::DRV_BANK_BIT];

  assign o_ch2_range_active = range_act_q;

  bcr_chan_map #(
    .OFF_TIME_LSB (bcr_pkg::TOFF1_LSB),
    .OCD_BIT  (bcr_pkg::GEN_OCD1_BIT),
    .EN_BIT   (bcr_pkg::GEN_EN1_BIT),
    .NO_LSB   (bcr_pkg::DRV_NO1_LSB),
    .LS_BIT   (bcr_pkg::DRV_LS1_BIT),
    .REV_BIT  (bcr_pkg::DRV_REV1_BIT)
  ) u_ch1_map (
    .i_off_time (off_time_q),
    .i_gen  (gen_q),
    .i_drv  (drv_q),
    .o_chan (o_ch1)
  );

  bcr_chan_map #(
    .OFF_TIME_LSB (bcr_pkg::TOFF2_LSB),
    .OCD_BIT  (bcr_pkg::GEN_OCD2_BIT),
    .EN_BIT   (bcr_pkg::GEN_EN2_BIT),
    .NO_LSB   (bcr_pkg::DRV_NO2_LSB),
    .LS_BIT   (bcr_pkg::DRV_LS2_BIT),
    .REV_BIT  (bcr_pkg::DRV_REV2_BIT)
  ) u_ch2_map (
    .i_off_time (off_time_q),
    .i_gen  (gen_q),
    .i_drv  (drv_q),
    .o_chan (o_ch2)
  );

  assign o_driver_slope_slow = gen_q[bcr_pkg::GEN_SLOW_BIT];

  assign o_overcurrent_filter_periods = gen_q[bcr_pkg::GEN_OCF_LSB +: 2];

  assign o_failsafe_mode_select = gen_q[bcr_pkg::GEN_FSM_LSB +: 3];

  always_comb begin
    o_failsafe = '0;
    case (o_failsafe_mode_select)
      bcr_pkg::FSM_OFF_SAFE: begin
        o_failsafe = '0;
      end
      bcr_pkg::FSM_OFF_OTP: begin
        o_failsafe.load_from_otp = 1'b1;
      end
      bcr_pkg::FSM_ON_SAFE: begin
        o_failsafe.failsafe_operation = 1'b1;
      end
      bcr_pkg::FSM_ON_SAFE_UPD: begin
        o_failsafe.failsafe_operation     = 1'b1;
        o_failsafe.spi_update_in_failsafe = 1'b1;
      end
      bcr_pkg::FSM_ON_OTP: begin
        o_failsafe.failsafe_operation = 1'b1;
        o_failsafe.load_from_otp      = 1'b1;
      end
      bcr_pkg::FSM_ON_OTP_UPD: begin
        o_failsafe.failsafe_operation     = 1'b1;
        o_failsafe.load_from_otp          = 1'b1;
        o_failsafe.spi_update_in_failsafe = 1'b1;
      end
      bcr_pkg::FSM_ALONE_OTP: begin
        o_failsafe.standalone    = 1'b1;
        o_failsafe.load_from_otp = 1'b1;
      end
      bcr_pkg::FSM_ALONE_OTP_UPD: begin
        o_failsafe.standalone             = 1'b1;
        o_failsafe.load_from_otp          = 1'b1;
        o_failsafe.spi_update_in_failsafe = 1'b1;
      end
      default: begin
        o_failsafe = '0;
      end
    endcase
  end

  assign o_sync_enable = drv_q[bcr_pkg::DRV_SYNC_BIT];

endmodule

// One configuration word: cleared by reset and loaded whole by a write to its address.
module bcr_cfg_reg #(
  parameter int unsigned      WIDTH = 10,
  parameter logic [4:0]       ADDR  = 5'h00,
  parameter logic [WIDTH-1:0] RST   = '0
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_wr_en,
  input  wire logic [4:0]       i_addr,
  input  wire logic [WIDTH-1:0] i_wdata,
  output logic      [WIDTH-1:0] o_value
);

  logic             hit;
  logic [WIDTH-1:0] value_q;

  if (WIDTH == 0) begin : g_bad_width
    $error("a configuration word needs at least one bit");
  end

  assign hit = i_wr_en && (i_addr == ADDR);

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      value_q <= RST;
    end else if (hit) begin
      value_q <= i_wdata;
    end
  end

  assign o_value = value_q;

endmodule

// Gathers one channel's controls from the three configuration words.
module bcr_chan_map #(
  parameter int unsigned OFF_TIME_LSB = 0,
  parameter int unsigned OCD_BIT  = 0,
  parameter int unsigned EN_BIT   = 0,
  parameter int unsigned NO_LSB   = 0,
  parameter int unsigned LS_BIT   = 0,
  parameter int unsigned REV_BIT  = 0
) (
  input  wire logic [bcr_pkg::DATA_W-1:0] i_off_time,
  input  wire logic [bcr_pkg::DATA_W-1:0] i_gen,
  input  wire logic [bcr_pkg::DATA_W-1:0] i_drv,
  output bcr_pkg::bcr_chan_s              o_chan
);

  // A field placed past the word would read bits that do not exist.
  if (OFF_TIME_LSB + 5 > bcr_pkg::DATA_W) begin : g_bad_off_time
    $error("off-time field runs past the register word");
  end
  if (NO_LSB + 2 > bcr_pkg::DATA_W) begin : g_bad_no
    $error("non-overlap field runs past the register word");
  end
  if (OCD_BIT >= bcr_pkg::DATA_W || EN_BIT >= bcr_pkg::DATA_W) begin : g_bad_gen
    $error("general settings bit lies past the register word");
  end
  if (LS_BIT >= bcr_pkg::DATA_W || REV_BIT >= bcr_pkg::DATA_W) begin : g_bad_drv
    $error("driver settings bit lies past the register word");
  end

  always_comb begin
    o_chan                          = '0;
    o_chan.regulator_enable         = i_gen[EN_BIT];
    o_chan.off_time_constant        = i_off_time[OFF_TIME_LSB +: 5];
    o_chan.offset_cancel_disable    = i_gen[OCD_BIT];
    o_chan.nonoverlap_select        = i_drv[NO_LSB +: 2];
    o_chan.lowside_predriver_enable = i_drv[LS_BIT];
    o_chan.reverse_current_ignore   = i_drv[REV_BIT];
  end

endmodule

// file: sim/bcr_buck_regs_assertions.sv
// Purpose: Port-level checks for the buck channel control registers.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   Bound to the register block from the bench top.
module bcr_buck_regs_chk (
  input wire logic                  i_ref_clk,
  input wire logic                  i_nrst,
  input wire logic                  i_wr_en,
  input wire logic                  i_rd_en,
  input wire logic [4:0]            i_addr,
  input wire logic [9:0]            i_wdata,
  input wire logic [9:0]            o_rdata,
  input wire logic                  o_trim_read_ch2,
  input wire logic [2:0]            o_ch2_range_active,
  input wire bcr_pkg::bcr_chan_s    o_ch1,
  input wire bcr_pkg::bcr_chan_s    o_ch2,
  input wire logic                  o_driver_slope_slow,
  input wire logic [1:0]            o_overcurrent_filter_periods,
  input wire logic [2:0]            o_failsafe_mode_select,
  input wire bcr_pkg::bcr_failsafe_s o_failsafe,
  input wire logic                  o_sync_enable
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_range_then_value;
    i_wr_en && i_addr == 5'h03 && i_wdata[2:0] <= 3'h4 ##1 !i_wr_en ##1 i_wr_en && i_addr == 5'h02;
  endsequence
  sequence s_bank_then_trim;
    i_wr_en && i_addr == 5'h06 ##1 !i_wr_en ##1 !i_wr_en && i_addr == 5'h19;
  endsequence
  chk_range_apply: assert property (
    s_range_then_value |=> o_ch2_range_active == $past(i_wdata[2:0], 3)) else $error("range not applied");
  chk_range_hold: assert property (
    !(i_wr_en && i_addr == 5'h02) |=> $stable(o_ch2_range_active)) else $error("range moved early");
  chk_range_legal: assert property (o_ch2_range_active <= 3'h4) else $error("range code illegal");
  chk_off_time_fields: assert property (
    i_wr_en && i_addr == 5'h04 |=> {o_ch1.off_time_constant, o_ch2.off_time_constant} == $past(i_wdata))
    else $error("off-time fields wrong");
  chk_enable_bits: assert property (
    i_wr_en && i_addr == 5'h05 |=> {o_ch1.regulator_enable, o_ch2.regulator_enable} == $past(i_wdata[1:0]))
    else $error("enable bits wrong");
  chk_general_read: assert property (
    i_rd_en && !i_wr_en && i_addr == 5'h05 |=> o_rdata == {o_ch1.offset_cancel_disable,
    o_ch2.offset_cancel_disable, o_driver_slope_slow, o_overcurrent_filter_periods,
    o_failsafe_mode_select, o_ch1.regulator_enable, o_ch2.regulator_enable}) else $error("read mismatch");
  chk_unmapped_read: assert property (
    i_rd_en && i_addr == 5'h1f |=> o_rdata == 10'h000) else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!i_rd_en |=> $stable(o_rdata)) else $error("read data moved");
  chk_sync_bits: assert property (
    i_wr_en && i_addr == 5'h06 |=> {o_sync_enable, o_ch1.nonoverlap_select} == $past(i_wdata[9:7]))
    else $error("sync or overlap wrong");
  chk_failsafe_on: assert property (
    o_failsafe.failsafe_operation == (o_failsafe_mode_select inside {[3'h2:3'h5]})) else $error("failsafe decode");
  chk_alone_decode: assert property (
    o_failsafe.standalone == (o_failsafe_mode_select >= 3'h6)) else $error("stand-alone decode");
  chk_trim_bank: assert property (
    s_bank_then_trim |-> o_trim_read_ch2 == $past(i_wdata[0], 2)) else $error("trim bank wrong");
endmodule

// file: sim/bcr_host_model.sv
// Purpose: Host side of the register port, issuing single write and read strobes.
// Assumes: Tasks are called just after a falling clock edge.
// Notes:   Write data is inverted once released so stale values are never read as valid.
module bcr_host_model (
  input  wire logic       i_ref_clk,
  input  wire logic [9:0] i_rdata,
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic [4:0]      o_addr,
  output logic [9:0]      o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 5'h00;
    o_wdata = 10'h000;
  end
  task automatic wr(input logic [4:0] a, input logic [9:0] d);
    o_addr  = a;
    o_wdata = d;
    o_wr_en = 1'b1;
    @(negedge i_ref_clk);
    o_wr_en = 1'b0;
    o_wdata = ~d;
    @(negedge i_ref_clk);
  endtask
  task automatic rd(input logic [4:0] a, output logic [9:0] d);
    o_addr  = a;
    o_rd_en = 1'b1;
    @(negedge i_ref_clk);
    o_rd_en = 1'b0;
    d = i_rdata;
    @(negedge i_ref_clk);
  endtask
endmodule

// file: sim/tb.sv
// Purpose: Self-checking bench for the buck channel control registers.
// Assumes: 10 MHz clock, reset held four cycles.
// Notes:   Expected values follow the documented field layout.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic wr, rd, trim, slow, sync;
  logic [4:0] addr;
  logic [9:0] wdata, rdata, v;
  logic [2:0] rng, fsm;
  logic [1:0] ocf;
  bcr_pkg::bcr_chan_s ch1, ch2;
  bcr_pkg::bcr_failsafe_s fs;
  int miscompares = 0;
  int num_checks = 0;
  logic [9:0] pats [4] = '{10'h3ff, 10'h2aa, 10'h155, 10'h000};
  initial forever #50 i_ref_clk = ~i_ref_clk;
  bcr_host_model u_host (.i_ref_clk(i_ref_clk), .i_rdata(rdata), .o_wr_en(wr), .o_rd_en(rd),
    .o_addr(addr), .o_wdata(wdata));
  bcr_buck_regs u_dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_wr_en(wr), .i_rd_en(rd), .i_addr(addr),
    .i_wdata(wdata), .o_rdata(rdata), .o_trim_read_ch2(trim), .o_ch2_range_active(rng), .o_ch1(ch1),
    .o_ch2(ch2), .o_driver_slope_slow(slow), .o_overcurrent_filter_periods(ocf),
    .o_failsafe_mode_select(fsm), .o_failsafe(fs), .o_sync_enable(sync));
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #1ms;
    miscompares++;
    wrap_up();
  end
  initial begin
    logic [9:0] d4, d5, d6;
    repeat (4) @(negedge i_ref_clk);
    i_nrst = 1'b1;
    for (int a = 3; a < 7; a++) begin
      u_host.rd(5'(a), v);
      chk("reset value", 11'h000, {1'b0, v});
    end
    chk("reset outputs", 11'h000, {trim, rng, slow, ocf, fsm, sync});
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      d4 = pats[i];
      d5 = pats[(i + 1) % 4];
      d6 = pats[(i + 2) % 4];
      u_host.wr(5'h04, d4);
      u_host.wr(5'h05, d5);
      u_host.wr(5'h06, d6);
      u_host.rd(5'h19, v);
      chk("trim bank", {10'h000, d6[0]}, {10'h000, trim});
      u_host.wr(5'h1f, ~d5);
      chk("ch1", {d5[1], d4[9:5], d5[9], d6[8:7], d6[4], d6[2]}, ch1);
      chk("ch2", {d5[0], d4[4:0], d5[8], d6[6:5], d6[3], d6[1]}, ch2);
      chk("misc", {4'h0, d5[7:2], d6[9]}, {4'h0, slow, ocf, fsm, sync});
      u_host.rd(5'h05, v);
      chk("readback 05", {1'b0, d5}, {1'b0, v});
      u_host.rd(5'h1f, v);
      chk("unmapped", 11'h000, {1'b0, v});
    end
    $display("field test done");
    for (int c = 0; c < 8; c++) begin
      u_host.wr(5'h05, 10'(c << 2));
      chk("failsafe", {7'h00, c inside {[2:5]}, c >= 6, c == 1 || c >= 4, c == 3 || c == 5 || c == 7}, fs);
    end
    $display("failsafe test done");
    for (int c = 4; c >= 0; c--) begin
      u_host.wr(5'h03, 10'(c));
      chk("range pending", {8'h00, 3'(c == 4 ? 0 : c + 1)}, {8'h00, rng});
      u_host.wr(5'h02, 10'h0db);
      chk("range applied", {8'h00, 3'(c)}, {8'h00, rng});
    end
    u_host.wr(5'h03, 10'h005);
    u_host.wr(5'h02, 10'h000);
    chk("range illegal", 11'h000, {8'h00, rng});
    $display("range test done");
    wrap_up();
  end
endmodule
bind bcr_buck_regs bcr_buck_regs_chk u_chk (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_wr_en(i_wr_en),
  .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_trim_read_ch2(o_trim_read_ch2),
  .o_ch2_range_active(o_ch2_range_active), .o_ch1(o_ch1), .o_ch2(o_ch2), .o_driver_slope_slow(o_driver_slope_slow),
  .o_overcurrent_filter_periods(o_overcurrent_filter_periods), .o_failsafe_mode_select(o_failsafe_mode_select),
  .o_failsafe(o_failsafe), .o_sync_enable(o_sync_enable));
